// ---- core/fdcrs_pkg.sv ----
// shared constants and types for the floppy rate, input and status registers
package fdcrs_pkg;

   // ==========================================================
   // compatibility modes
   typedef enum logic [1:0] {
      FDCRS_LEGACY,
      FDCRS_ENHANCED,
      FDCRS_COMPACT
   } fdcrs_mode_type;

   // ==========================================================
   // host addressing
   localparam int          HOST_ADDR_W  = 10;
   localparam logic [9:0]  RATE_IO_ADDR = 10'h3f7;  // input reg on read, config reg on write

   // ==========================================================
   // data rate codes in the rate-select field
   localparam logic [1:0]  RATE_500K    = 2'h0;
   localparam logic [1:0]  RATE_300K    = 2'h1;
   localparam logic [1:0]  RATE_250K    = 2'h2;
   localparam logic [1:0]  RATE_1M      = 2'h3;
   localparam logic [1:0]  RATE_RESET   = RATE_250K;

   // ==========================================================
   // reset values
   localparam logic        PRECOMP_RESET = 1'h0;
   localparam logic        DENSITY_RESET = 1'h1;

   // ==========================================================
   // field positions
   localparam int          CHG_BIT       = 7;   // disk change, every mode
   localparam int          LOWDENS_BIT   = 0;   // enhanced layout
   localparam int          ENH_RATE_LSB  = 1;   // enhanced layout
   localparam int          CMP_RATE_LSB  = 0;   // compact layout
   localparam int          CMP_PREC_BIT  = 2;   // compact layout
   localparam int          CMP_DMA_BIT   = 3;   // compact layout
   localparam int          CFG_RATE_LSB  = 0;   // config register
   localparam int          CFG_PREC_BIT  = 2;   // config register, compact only

   // ==========================================================
   // constant fields and drive masks
   localparam logic [3:0]  ENH_FILL      = 4'hf;
   localparam logic [2:0]  CMP_FILL      = 3'h0;
   localparam logic [7:0]  LEGACY_OE     = 8'h80;
   localparam logic [7:0]  FULL_OE       = 8'hff;

   // ==========================================================
   // first result status byte
   localparam logic [1:0]  TERM_NORMAL   = 2'h0;
   localparam logic [1:0]  TERM_ABNORMAL = 2'h1;
   localparam logic [1:0]  TERM_INVALID  = 2'h2;
   localparam logic [1:0]  TERM_POLLING  = 2'h3;
   localparam int          RECAL_STEPS   = 80;
endpackage

// ---- core/fdcrs_sync.sv ----
// two-stage synchroniser for drive cable levels
`timescale 1ns/100ps

module fdcrs_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   // levels
   input  wire logic [WIDTH-1:0] asyncIn,
   output      logic [WIDTH-1:0] syncOut
);
   import fdcrs_pkg::*;

   logic [WIDTH-1:0] stage1_ff;

   // first stage feeds the second stage only
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stage1_ff <= '0;
         syncOut   <= '0;
      end else begin
         stage1_ff <= asyncIn;
         syncOut   <= stage1_ff;
      end
   end
endmodule

// ---- core/fdcrs_status0.sv ----
// builder of the first result status byte
`timescale 1ns/100ps

module fdcrs_status0 #(
   parameter int STEP_LIMIT = fdcrs_pkg::RECAL_STEPS
) (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   // command engine events
   input  wire logic       cmdEnd,
   input  wire logic [1:0] termination_code,
   input  wire logic       positioning_finished,
   input  wire logic       recalActive,
   input  wire logic       stepPulse,
   input  wire logic       relSeekPastZero,
   input  wire logic       trackZeroSync,
   input  wire logic       headNow,
   input  wire logic [1:0] unit_select,
   // result
   output      logic [7:0] statusZero,
   output      logic       statusValid
);
   import fdcrs_pkg::*;

   logic [7:0] stepCount_ff;
   logic       equipFault_ff;
   wire        lastStep  = stepPulse && recalActive &&
                           (stepCount_ff == 8'(STEP_LIMIT - 1));
   wire        faultHit  = (lastStep && !trackZeroSync) || relSeekPastZero;
   wire        equip_fault = equipFault_ff | faultHit;  // a set in the end cycle still reaches the latched byte; the end clear wins in the register
   wire [7:0]  nxt_statusZero = {termination_code, positioning_finished,
                                 equip_fault, 1'b0, headNow, unit_select};

   // step counter only runs inside a recalibrate
   always_ff @(posedge ref_clk) begin
      if (sys_rst || !recalActive)
         stepCount_ff <= 8'h00;
      else if (stepPulse && stepCount_ff != 8'hff)
         stepCount_ff <= stepCount_ff + 8'h01;
   end

   // fault is held until the byte is latched at command end
   always_ff @(posedge ref_clk) begin
      if (sys_rst)
         equipFault_ff <= 1'b0;
      else
         equipFault_ff <= cmdEnd ? 1'b0 : equip_fault;
   end

   // byte presented for the result phase
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         statusZero  <= 8'h00;
         statusValid <= 1'b0;
      end else begin
         statusValid <= cmdEnd;
         if (cmdEnd)
            statusZero <= nxt_statusZero;
      end
   end

   // ==========================================================
   // checks
   st0_code_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cmdEnd |=> statusValid && statusZero[7:6] == $past(termination_code))
      else $error("termination code not latched");
   st0_fault_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (faultHit && !cmdEnd) ##1 !cmdEnd ##1 cmdEnd |=> statusZero[4])
      else $error("equipment fault lost");
   st0_fixed_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
      statusValid |-> !statusZero[3])
      else $error("bit 3 of status byte set");
endmodule

// ---- core/fdcrs_regs.sv ----
// rate configuration, digital input register and status byte top
`timescale 1ns/100ps

// Function
// - reads at the shared address return the read-only input register.
// - legacy mode drives only bit 7; bits 0-6 stay undriven.
// - bit 7 always returns the inverted disk change cable level.
// - enhanced bit 0 is low for 500K or 1M, high for 250K/300K.
// - enhanced layout shows rate bits at 1-2 and ones in 3-6.
// - rate bits survive soft reset; hardware reset selects 250K.
// - compact layout shows rate bits at 0-1 and zeros in 4-6.
// - compact bit 2 mirrors the last written precompensation-off bit.
// - compact bit 3 mirrors the DMA gate enable of the output register.
// - writes at the shared address load the config register rate field.
// - compact config bit 2 is stored, inert, and survives soft reset.
// - density pin goes high on hardware reset or on a write of the 500K or 1M code.
// - the first status byte of a finished command is presented for reading.
// - status byte bits 7:6 encode how the command terminated.
// - status byte bit 5 flags a finished seek or recalibrate.
// - status byte bit 4 flags track zero missing after 80 steps.
// - status byte bit 3 is zero, bit 2 head, bits 1:0 drive.
module fdcrs_regs #(
   parameter int STEP_LIMIT = fdcrs_pkg::RECAL_STEPS
) (
   // clock and resets
   input  wire logic                    ref_clk,
   input  wire logic                    sys_rst,
   input  wire logic                    softRst,
   // host bus, same clock domain
   input  wire logic [9:0]              hostAddr,
   input  wire logic                    hostRead,
   input  wire logic                    hostWrite,
   input  wire logic [7:0]              hostDataIn,
   output      logic [7:0]              hostDataOut,
   output      logic [7:0]              hostDataOe,
   // configuration
   input  wire fdcrs_pkg::fdcrs_mode_type compatMode,
   input  wire logic                    dma_gate_enable,
   // drive cable
   input  wire logic                    disk_change_flag,
   input  wire logic                    track_zero_sense,
   output      logic                    density_select_pin,
   // data separator
   output      logic [1:0]              rateSelect,
   output      logic                    precomp_off_bit,
   // command engine
   input  wire logic                    cmdEnd,
   input  wire logic [1:0]              termination_code,
   input  wire logic                    positioning_finished,
   input  wire logic                    recalActive,
   input  wire logic                    stepPulse,
   input  wire logic                    relSeekPastZero,
   input  wire logic                    headNow,
   input  wire logic [1:0]              unit_select,
   output      logic [7:0]              result_status_zero,
   output      logic                    resultValid
);
   import fdcrs_pkg::*;

   // ==========================================================
   // cable inputs
   logic       chgSync;
   logic       trackZeroSync;

   // both cable levels are asynchronous to the host clock
   // so the change bit lags the cable by two clocks after any edge
   fdcrs_sync #(
      .WIDTH (2)
   ) u_cable_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .asyncIn ({disk_change_flag, track_zero_sense}),
      .syncOut ({chgSync, trackZeroSync})
   );

   // ==========================================================
   // address decode
   // one address serves both directions; the strobe picks the register
   wire        addrHit   = (hostAddr == RATE_IO_ADDR);
   wire        dirRead   = hostRead && addrHit;
   wire        cfgWrite  = hostWrite && addrHit;
   wire        isCompact = (compatMode == FDCRS_COMPACT);

   // ==========================================================
   // configuration control register
   logic [1:0] rate_ff;
   logic       precomp_ff;
   logic       density_ff;
   wire  [1:0] nxt_rate    = hostDataIn[CFG_RATE_LSB +: 2];
   // reserved bits are not stored; in legacy and enhanced bit 2 is reserved
   wire        nxt_precomp = isCompact ? hostDataIn[CFG_PREC_BIT] : precomp_ff;
   // low-density codes drop the pin, high-density codes raise it
   wire        nxt_density = (nxt_rate == RATE_500K) || (nxt_rate == RATE_1M);

   // soft reset is deliberately ignored: rate, precomp and density keep their values
   // a read in the same cycle as a write still returns the old values
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rate_ff    <= RATE_RESET;
         precomp_ff <= PRECOMP_RESET;
         density_ff <= DENSITY_RESET;
      end else if (cfgWrite) begin
         rate_ff    <= nxt_rate;
         precomp_ff <= nxt_precomp;
         density_ff <= nxt_density;
      end
   end

   assign rateSelect         = rate_ff;
   assign precomp_off_bit    = precomp_ff;
   assign density_select_pin = density_ff;

   // ==========================================================
   // digital input register layouts
   wire        chgBit       = ~chgSync;
   wire        lowDensity   = rate_ff[1] ^ rate_ff[0];
   wire  [7:0] legacyByte   = {chgBit, 7'h00};
   wire  [7:0] enhancedByte = {chgBit, ENH_FILL, rate_ff, lowDensity};
   wire  [7:0] compactByte  = {chgBit, CMP_FILL, dma_gate_enable,
                               precomp_ff, rate_ff};
   logic [7:0] dirByte;
   logic [7:0] dirOe;

   // layout selection; the unused code falls back to legacy
   // an unknown mode code must never leave the bus driven wide
   always_comb begin
      unique case (compatMode)
         FDCRS_ENHANCED: begin
            dirByte = enhancedByte;
            dirOe   = FULL_OE;
         end
         FDCRS_COMPACT: begin
            dirByte = compactByte;
            dirOe   = FULL_OE;
         end
         default: begin
            dirByte = legacyByte;
            dirOe   = LEGACY_OE;
         end
      endcase
   end

   // ==========================================================
   // read return, one cycle after the read strobe
   // the enables fall one cycle after the strobe so undriven bits never fight the bus
   // undriven legacy bits are also forced low so the data word stays defined
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         hostDataOut <= 8'h00;
         hostDataOe  <= 8'h00;
      end else begin
         hostDataOut <= dirRead ? (dirByte & dirOe) : 8'h00;
         hostDataOe  <= dirRead ? dirOe : 8'h00;
      end
   end

   // ==========================================================
   // first result status byte
   // the byte and its valid pulse are built in a sub-block of their own
   fdcrs_status0 #(
      .STEP_LIMIT (STEP_LIMIT)
   ) u_status0 (
      .ref_clk              (ref_clk),
      .sys_rst              (sys_rst),
      .cmdEnd               (cmdEnd),
      .termination_code     (termination_code),
      .positioning_finished (positioning_finished),
      .recalActive          (recalActive),
      .stepPulse            (stepPulse),
      .relSeekPastZero      (relSeekPastZero),
      .trackZeroSync        (trackZeroSync),
      .headNow              (headNow),
      .unit_select          (unit_select),
      .statusZero           (result_status_zero),
      .statusValid          (resultValid)
   );

   // ==========================================================
   // checks
   // all checks run on the host clock and stand down during hardware reset
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   // a read strobe and its one-cycle answer
   sequence readCycle;
      dirRead ##1 (hostDataOe != 8'h00);
   endsequence

   sequence legacyRead;
      dirRead && compatMode == FDCRS_LEGACY;
   endsequence

   sequence enhancedRead;
      dirRead && compatMode == FDCRS_ENHANCED;
   endsequence

   sequence compactRead;
      dirRead && isCompact;
   endsequence

   // read answer timing; back to back reads keep the enables up
   input_decode_a: assert property (
      dirRead |-> readCycle ##1 (hostDataOe == 8'h00 || $past(dirRead)))
      else $error("input register read not answered for one cycle");

   idle_bus_a: assert property (
      !$past(dirRead) |-> hostDataOe == 8'h00)
      else $error("data bus driven without a read");

   idle_data_a: assert property (
      !$past(dirRead) |-> hostDataOut == 8'h00)
      else $error("read data shown without a read");

   read_only_a: assert property (
      cfgWrite && !dirRead |=> hostDataOe == 8'h00)
      else $error("write at the shared address answered as a read");

   // layouts, each checked in the cycle after its read strobe
   legacy_float_a: assert property (
      legacyRead |=> hostDataOe == LEGACY_OE && hostDataOut[6:0] == 7'h00)
      else $error("legacy read drives low bits");

   full_drive_a: assert property (
      dirRead && (compatMode == FDCRS_ENHANCED || isCompact) |=> hostDataOe == FULL_OE)
      else $error("wide layout not fully driven");

   change_inv_a: assert property (
      dirRead |=> hostDataOut[CHG_BIT] == !$past(chgSync))
      else $error("disk change bit not inverted");

   low_density_a: assert property (
      enhancedRead |=> hostDataOut[LOWDENS_BIT] ==
         ($past(rate_ff) == RATE_250K || $past(rate_ff) == RATE_300K))
      else $error("low density flag wrong");

   enhanced_layout_a: assert property (
      enhancedRead |=> hostDataOut[6:3] == ENH_FILL &&
         hostDataOut[ENH_RATE_LSB +: 2] == $past(rate_ff))
      else $error("enhanced layout wrong");

   compact_layout_a: assert property (
      compactRead |=> hostDataOut[6:4] == CMP_FILL &&
         hostDataOut[CMP_RATE_LSB +: 2] == $past(rate_ff))
      else $error("compact layout wrong");

   precomp_mirror_a: assert property (
      (cfgWrite && isCompact) ##1 !cfgWrite ##1 compactRead |=>
         hostDataOut[CMP_PREC_BIT] == $past(hostDataIn[CFG_PREC_BIT], 3))
      else $error("precomp bit not mirrored");

   dma_mirror_a: assert property (
      compactRead |=> hostDataOut[CMP_DMA_BIT] == $past(dma_gate_enable))
      else $error("dma gate enable not mirrored");

   // rate field; only a write or a hardware reset may move it
   rate_soft_a: assert property (
      softRst && !cfgWrite |=> $stable(rate_ff) && $stable(precomp_ff))
      else $error("rate changed on soft reset");

   rate_hard_a: assert property (
      $fell(sys_rst) |-> rate_ff == RATE_250K)
      else $error("rate not 250K after hardware reset");

   rate_hold_a: assert property (
      !cfgWrite |=> $stable(rateSelect))
      else $error("rate moved without a write");

   rate_write_a: assert property (
      cfgWrite |=> rateSelect == $past(hostDataIn[1:0]))
      else $error("rate field not written");

   unmapped_write_a: assert property (
      hostWrite && !addrHit |=> $stable(rateSelect) && $stable(precomp_off_bit))
      else $error("write to another address stored");

   // stored precompensation bit, inert outside compact mode
   precomp_keep_a: assert property (
      cfgWrite && !isCompact |=> $stable(precomp_ff))
      else $error("reserved bit 2 stored outside compact mode");

   precomp_store_a: assert property (
      cfgWrite && isCompact |=> precomp_off_bit == $past(hostDataIn[CFG_PREC_BIT]))
      else $error("precomp bit not stored in compact mode");

   // density pin: hardware reset and writes only
   density_reset_a: assert property (
      $fell(sys_rst) |-> density_select_pin ##1 ($past(cfgWrite) || density_select_pin))
      else $error("density pin not high after hardware reset");

   density_soft_a: assert property (
      softRst && !cfgWrite |=> $stable(density_select_pin))
      else $error("density pin moved on soft reset");

   density_hold_a: assert property (
      !cfgWrite |=> $stable(density_select_pin))
      else $error("density pin moved without a write");

   density_follow_a: assert property (
      cfgWrite |=> density_select_pin ==
         ($past(hostDataIn[1:0]) == RATE_500K || $past(hostDataIn[1:0]) == RATE_1M))
      else $error("density pin does not follow the written rate");
endmodule

// ---- dv/fdcrs_host_model.sv ----
// host processor model that drives the register strobes of the rate and input registers
`timescale 1ns/100ps

module fdcrs_host_model (
   // clock
   input  wire logic       ref_clk,
   // layout hint, decides which config bits are reserved
   input  wire logic       compactMode,
   // host bus
   output      logic [9:0] hostAddr,
   output      logic       hostRead,
   output      logic       hostWrite,
   output      logic [7:0] hostDataIn,
   input  wire logic [7:0] hostDataOut,
   input  wire logic [7:0] hostDataOe
);
   logic [7:0] keepMask;

   // ==========================================================
   // reserved bits
   // reserved config bits go out as zero while the write strobe is up
   assign keepMask = compactMode ? 8'h07 : 8'h03;

   // idle bus at time zero
   initial begin
      hostAddr   = 10'h000;
      hostRead   = 1'h0;
      hostWrite  = 1'h0;
      hostDataIn = 8'h00;
   end

   // ==========================================================
   // bus cycles
   // one-cycle write strobe; the released bus shows the inverse, not stale values
   task automatic wr(input logic [9:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      hostAddr   <= addr;
      hostDataIn <= data & keepMask;
      hostWrite  <= 1'h1;
      @(posedge ref_clk);
      hostWrite  <= 1'h0;
      hostAddr   <= ~addr;
      hostDataIn <= ~(data & keepMask);
   endtask

   // one-cycle read strobe; data and enables stand only in the following cycle
   task automatic rd(input logic [9:0] addr, output logic [7:0] data, output logic [7:0] oe);
      @(posedge ref_clk);
      hostAddr <= addr;
      hostRead <= 1'h1;
      @(posedge ref_clk);
      hostRead <= 1'h0;
      hostAddr <= ~addr;
      #1;
      data = hostDataOut;
      oe   = hostDataOe;
   endtask
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the floppy rate, input and status registers
`timescale 1ns/100ps

module tb;
   import fdcrs_pkg::*;
   localparam int STEPS = 4;  // short recalibrate count keeps the run brief

   typedef struct packed {
      fdcrs_mode_type mode;
      logic [7:0]     wdata;
      logic           dma;
      logic           chg;
      logic [7:0]     expOut;
      logic [7:0]     expOe;
      logic [1:0]     expRate;
      logic           expDens;
      logic           expPrec;
   } fdcrs_row_type;

   // ==========================================================
   // signals
   logic           ref_clk = 1'h0;
   logic           sys_rst = 1'h1;
   logic           softRst = 1'h0;
   fdcrs_mode_type compatMode = FDCRS_LEGACY;
   logic           dma_gate_enable = 1'h0;
   logic           disk_change_flag = 1'h0;
   logic           track_zero_sense = 1'h0;
   logic           cmdEnd = 1'h0;
   logic [1:0]     termination_code = 2'h0;
   logic           positioning_finished = 1'h0;
   logic           recalActive = 1'h0;
   logic           stepPulse = 1'h0;
   logic           relSeekPastZero = 1'h0;
   logic           headNow = 1'h0;
   logic [1:0]     unit_select = 2'h0;
   logic [9:0]     hostAddr;
   logic           hostRead, hostWrite;
   logic [7:0]     hostDataIn, hostDataOut, hostDataOe, result_status_zero, rdData, rdOe;
   logic [1:0]     rateSelect;
   logic           density_select_pin, precomp_off_bit, resultValid;
   int             nMismatch = 0;
   int             checked = 0;

   // ordinary cases: mode, written byte, dma, cable level, then expected read and state
   fdcrs_row_type rows [9] = '{
      '{FDCRS_LEGACY,   8'h00, 1'h0, 1'h1, 8'h00, 8'h80, 2'h0, 1'h1, 1'h0},
      '{FDCRS_LEGACY,   8'h03, 1'h1, 1'h0, 8'h80, 8'h80, 2'h3, 1'h1, 1'h0},
      '{FDCRS_ENHANCED, 8'h01, 1'h0, 1'h0, 8'hfb, 8'hff, 2'h1, 1'h0, 1'h0},
      '{FDCRS_ENHANCED, 8'h00, 1'h0, 1'h1, 8'h78, 8'hff, 2'h0, 1'h1, 1'h0},
      '{FDCRS_ENHANCED, 8'h03, 1'h1, 1'h1, 8'h7e, 8'hff, 2'h3, 1'h1, 1'h0},
      '{FDCRS_ENHANCED, 8'h02, 1'h0, 1'h0, 8'hfd, 8'hff, 2'h2, 1'h0, 1'h0},
      '{FDCRS_COMPACT,  8'h06, 1'h1, 1'h0, 8'h8e, 8'hff, 2'h2, 1'h0, 1'h1},
      '{FDCRS_COMPACT,  8'h01, 1'h0, 1'h1, 8'h01, 8'hff, 2'h1, 1'h0, 1'h0},
      '{FDCRS_COMPACT,  8'h07, 1'h1, 1'h1, 8'h0f, 8'hff, 2'h3, 1'h1, 1'h1}
   };

   // ==========================================================
   // clock and instances
   always #12.5 ref_clk = ~ref_clk;

   fdcrs_regs #(.STEP_LIMIT(STEPS)) i_fdcrs_regs (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .softRst(softRst),
      .hostAddr(hostAddr), .hostRead(hostRead), .hostWrite(hostWrite),
      .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
      .compatMode(compatMode), .dma_gate_enable(dma_gate_enable),
      .disk_change_flag(disk_change_flag), .track_zero_sense(track_zero_sense),
      .density_select_pin(density_select_pin), .rateSelect(rateSelect),
      .precomp_off_bit(precomp_off_bit), .cmdEnd(cmdEnd), .termination_code(termination_code),
      .positioning_finished(positioning_finished), .recalActive(recalActive),
      .stepPulse(stepPulse), .relSeekPastZero(relSeekPastZero), .headNow(headNow),
      .unit_select(unit_select), .result_status_zero(result_status_zero),
      .resultValid(resultValid));

   fdcrs_host_model i_fdcrs_host_model (
      .ref_clk(ref_clk), .compactMode(compatMode == FDCRS_COMPACT),
      .hostAddr(hostAddr), .hostRead(hostRead), .hostWrite(hostWrite),
      .hostDataIn(hostDataIn), .hostDataOut(hostDataOut), .hostDataOe(hostDataOe));

   // ==========================================================
   // helpers
   task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         nMismatch++;
      end
   endtask

   // rate field, density pin and stored precompensation bit in one go
   task automatic chkState(input logic [1:0] r, input logic d, input logic p);
      chk("rateSelect", {6'h00, rateSelect}, {6'h00, r});
      chk("density_select_pin", {7'h00, density_select_pin}, {7'h00, d});
      chk("precomp_off_bit", {7'h00, precomp_off_bit}, {7'h00, p});
   endtask

   // one command end; the valid pulse stands in the next cycle only, the byte until the next end
   task automatic cmd(input logic [1:0] tc, input logic pf, input logic hd,
                      input logic [1:0] us, input logic ec);
      @(posedge ref_clk);
      termination_code <= tc;
      positioning_finished <= pf;
      headNow <= hd;
      unit_select <= us;
      cmdEnd <= 1'h1;
      @(posedge ref_clk);
      cmdEnd <= 1'h0;
      recalActive <= 1'h0;
      #1;
      chk("resultValid", {7'h00, resultValid}, 8'h01);
      chk("result_status_zero", result_status_zero, {tc, pf, ec, 1'h0, hd, us});
   endtask

   // recalibrate with n single-cycle step pulses
   task automatic steps(input int n);
      @(posedge ref_clk);
      recalActive <= 1'h1;
      repeat (n) begin
         @(posedge ref_clk);
         stepPulse <= 1'h1;
         @(posedge ref_clk);
         stepPulse <= 1'h0;
      end
   endtask

   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, nMismatch);
      if (nMismatch == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'h0;
      #1;
      chkState(RATE_RESET, DENSITY_RESET, PRECOMP_RESET);
      chk("reset status", result_status_zero, 8'h00);
      foreach (rows[i]) begin
         @(posedge ref_clk);
         compatMode <= rows[i].mode;
         dma_gate_enable <= rows[i].dma;
         disk_change_flag <= rows[i].chg;
         i_fdcrs_host_model.wr(RATE_IO_ADDR, rows[i].wdata);
         i_fdcrs_host_model.rd(RATE_IO_ADDR, rdData, rdOe);
         chk("input reg", rdData, rows[i].expOut);
         chk("input reg enables", rdOe, rows[i].expOe);
         chkState(rows[i].expRate, rows[i].expDens, rows[i].expPrec);
      end
      // soft reset keeps everything; only a hardware reset restores defaults
      i_fdcrs_host_model.wr(RATE_IO_ADDR, 8'h05);
      @(posedge ref_clk);
      softRst <= 1'h1;
      repeat (2) @(posedge ref_clk);
      softRst <= 1'h0;
      #1;
      chkState(2'h1, 1'h0, 1'h1);
      @(posedge ref_clk);
      sys_rst <= 1'h1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'h0;
      #1;
      chkState(RATE_RESET, DENSITY_RESET, PRECOMP_RESET);
      // a neighbouring address must neither answer nor store
      i_fdcrs_host_model.rd(10'h3f6, rdData, rdOe);
      chk("unmapped enables", rdOe, 8'h00);
      chk("unmapped data", rdData, 8'h00);
      i_fdcrs_host_model.wr(10'h3f6, 8'h03);
      #1;
      chkState(RATE_RESET, DENSITY_RESET, PRECOMP_RESET);
      // equipment fault: one step short, at the limit, at track zero, past track zero
      steps(STEPS - 1);
      cmd(TERM_ABNORMAL, 1'h1, 1'h0, 2'h1, 1'h0);
      steps(STEPS);
      cmd(TERM_ABNORMAL, 1'h1, 1'h1, 2'h2, 1'h1);
      track_zero_sense <= 1'h1;
      steps(STEPS);
      cmd(TERM_NORMAL, 1'h1, 1'h0, 2'h3, 1'h0);
      @(posedge ref_clk);
      relSeekPastZero <= 1'h1;
      @(posedge ref_clk);
      relSeekPastZero <= 1'h0;
      cmd(TERM_NORMAL, 1'h1, 1'h1, 2'h0, 1'h1);
      // every termination code, back to back, fault already cleared
      for (int t = 0; t < 4; t++) begin
         cmd(t[1:0], t[0], t[1], ~t[1:0], 1'h0);
      end
      // valid drops after one cycle while the last byte stays
      @(posedge ref_clk);
      #1;
      chk("resultValid", {7'h00, resultValid}, 8'h00);
      chk("status held", result_status_zero, {TERM_POLLING, 1'h1, 2'h0, 1'h1, 2'h0});
      conclude();
   end

   // watchdog well beyond the hundred or so cycles the sequence needs
   initial begin
      repeat (4000) @(posedge ref_clk);
      nMismatch++;
      conclude();
   end
endmodule
